// >>> hw/lock_seq_pkg.sv
// Constants for the host-side lock-bit set sequencer of a byte-wide flash.
// Assumes the flash sits on an asynchronous SRAM-like bus driven by this block.
package lock_seq_pkg;
  // Command bytes written to the command interface.
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_MASTER_CONFIRM = 8'hF1;
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  // Bit positions in operation_status.
  localparam int BIT_READY   = 7;
  localparam int BIT_ERASE_FAIL = 5;
  localparam int BIT_LOCK_FAIL  = 4;
  localparam int BIT_SUPPLY  = 3;
  localparam int BIT_PROTECT = 1;
  // Bus strobe timing, in ns, and cycle counts at 100 MHz.
  localparam int CLK_NS      = 10;
  localparam int STROBE_NS   = 100;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Result codes reported to the user.
  localparam logic [2:0] RES_OK       = 3'h0;
  localparam logic [2:0] RES_SUPPLY   = 3'h1;
  localparam logic [2:0] RES_PROTECT  = 3'h2;
  localparam logic [2:0] RES_SEQUENCE = 3'h3;
  localparam logic [2:0] RES_LOCKFAIL = 3'h4;
  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_SETUP, ST_WR_CONFIRM, ST_POLL, ST_CHECK,
    ST_WR_CLEAR, ST_WR_READ, ST_DONE
  } seq_state_t;
endpackage

// >>> hw/lock_seq_host.sv
// Host-side sequencer that sets block or master lock bits in a flash.
// Assumes flash pins are wired directly; inputs are synchronous to clk.
`timescale 1ns/1ps
module lock_seq_host (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // User command port.
  input  wire logic                startReq,
  input  wire logic                masterLock,
  input  wire logic                lastOp,
  input  wire logic [20:0]         lockAddr,
  input  wire logic                supplyOk,
  output logic                     busy,
  output logic                     doneStb,
  output logic [2:0]               result,
  output logic [7:0]               statusSeen,
  // Flash pins.
  output logic [20:0]              flashAddr,
  output logic [7:0]               dataOut,
  output logic                     dataOe,
  input  wire logic [7:0]          dataIn,
  output logic                     chipSel_n,
  output logic                     outEn_n,
  output logic                     writeEn_n,
  output logic                     reset_powerdown_n,
  input  wire logic                ready_busy_out_n
);
  import lock_seq_pkg::*;

  // ==========================================================
  // State and timing registers
  // ==========================================================
  seq_state_t   state_r;                 // Sequencer state.
  logic [7:0]   strobeCnt_r;             // Cycles left in current strobe.
  logic         phase_r;                 // Low: strobe active, high: recovery.
  logic         isRead_r;                // Current bus cycle is a read.
  logic         master_r;                // Latched master/block choice.
  logic         last_r;                  // Latched final-operation flag.
  logic [20:0]  addr_r;                  // Latched target address.
  logic         cycEnd;                  // Bus cycle completes this clock.

  assign cycEnd = phase_r && (strobeCnt_r == 8'h00);
  assign busy   = (state_r != ST_IDLE);

  // reset pin follows supply-ok while not in system reset.
  always_ff @(posedge clk) begin
    reset_powerdown_n <= !sys_rst && supplyOk;
  end

  // ==========================================================
  // Bus cycle timer: one strobe phase then one recovery phase
  // ==========================================================
  // Counts the strobe width and a matching recovery gap.
  // The check step reloads it too, so the write that follows gets a full strobe.
  always_ff @(posedge clk) begin
    if (sys_rst || state_r == ST_IDLE || state_r == ST_CHECK || state_r == ST_DONE) begin
      strobeCnt_r <= 8'(STROBE_CYC - 1);
      phase_r     <= 1'b0;
    end else if (strobeCnt_r != 8'h00) begin
      strobeCnt_r <= strobeCnt_r - 8'h01;
    end else begin
      strobeCnt_r <= 8'(STROBE_CYC - 1);
      phase_r     <= !phase_r;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Steps through setup, confirm, poll, check and cleanup writes.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r    <= ST_IDLE;
      master_r   <= 1'b0;
      last_r     <= 1'b0;
      addr_r     <= '0;
      result     <= RES_OK;
      statusSeen <= 8'h00;
      doneStb    <= 1'b0;
    end else begin
      doneStb <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Latch the order so the user may change its inputs afterwards.
          if (startReq) begin
            master_r <= masterLock;
            last_r   <= lastOp;
            addr_r   <= lockAddr;
            state_r  <= ST_WR_SETUP;
          end
        end
        // setup write with the lock setup command.
        ST_WR_SETUP: if (cycEnd) state_r <= ST_WR_CONFIRM;
        // confirm write selects block or master lock.
        ST_WR_CONFIRM: if (cycEnd) state_r <= ST_POLL;
        // every read now returns status; poll ready bit.
        ST_POLL: begin
          // Sample on the last strobe cycle, while the device still drives the bus.
          if (isRead_r && !phase_r && strobeCnt_r == 8'h00) begin
            statusSeen <= {dataIn[7:1], 1'b0};
          end
          // only trust lower bits once engine ready.
          if (cycEnd && statusSeen[BIT_READY] && ready_busy_out_n) begin
            state_r <= ST_CHECK;
          end
        end
        // supply fault checked first, then protect, then sequence.
        ST_CHECK: begin
          if (statusSeen[BIT_SUPPLY]) result <= RES_SUPPLY;
          // protection hit flags blocked lock attempts.
          else if (statusSeen[BIT_PROTECT]) result <= RES_PROTECT;
          // both fail bits mean improper sequence.
          else if (statusSeen[BIT_ERASE_FAIL] && statusSeen[BIT_LOCK_FAIL])
            result <= RES_SEQUENCE;
          // lock-fail bit alone means set failed.
          else if (statusSeen[BIT_LOCK_FAIL]) result <= RES_LOCKFAIL;
          else result <= RES_OK;
          // sticky errors are cleared before any retry.
          if (statusSeen[BIT_SUPPLY] || statusSeen[BIT_PROTECT] ||
              statusSeen[BIT_LOCK_FAIL] || statusSeen[BIT_ERASE_FAIL])
            state_r <= ST_WR_CLEAR;
          // status checked after each operation here.
          else if (last_r) state_r <= ST_WR_READ;
          else state_r <= ST_DONE;
        end
        // Clear the sticky error bits, then finish or return to array read.
        ST_WR_CLEAR: if (cycEnd) state_r <= last_r ? ST_WR_READ : ST_DONE;
        // final operation returns the device to array read.
        ST_WR_READ: if (cycEnd) state_r <= ST_DONE;
        // One-cycle completion pulse, then back to idle.
        ST_DONE: begin
          doneStb <= 1'b1;
          state_r <= ST_IDLE;
        end
        // Unused encodings fall back to idle.
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drive
  // ==========================================================
  // Drives address, data and strobes for the current bus cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flashAddr <= '0;
      dataOut   <= 8'h00;
      dataOe    <= 1'b0;
      chipSel_n <= 1'b1;
      outEn_n   <= 1'b1;
      writeEn_n <= 1'b1;
      isRead_r  <= 1'b0;
    end else begin
      // Address follows the latched target for every bus cycle.
      flashAddr <= addr_r;
      isRead_r  <= (state_r == ST_POLL);
      // Write data is the command byte of the current state.
      case (state_r)
        ST_WR_SETUP:   dataOut <= CMD_LOCK_SETUP;
        ST_WR_CONFIRM: dataOut <= master_r ? CMD_MASTER_CONFIRM : CMD_BLOCK_CONFIRM;
        ST_WR_CLEAR:   dataOut <= CMD_CLEAR_STATUS;
        ST_WR_READ:    dataOut <= CMD_READ_ARRAY;
        default:       dataOut <= 8'h00;
      endcase
      // chip select only during a bus cycle; output enable is read strobe.
      chipSel_n <= !(busy && state_r != ST_CHECK && state_r != ST_DONE && !phase_r);
      outEn_n   <= !(state_r == ST_POLL && !phase_r);
      writeEn_n <= !(busy && state_r != ST_POLL && state_r != ST_CHECK &&
                     state_r != ST_DONE && !phase_r);
      // host drives data only during writes, never with reads.
      dataOe    <= busy && state_r != ST_POLL && state_r != ST_CHECK &&
                   state_r != ST_DONE;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  // Bus drive and strobe checks; every strobe stays low for ten clocks.
  a_no_contention: assert property (@(posedge clk) disable iff (sys_rst)
    !(dataOe && !outEn_n)) else $error("Data driven while read strobe active.");
  a_strobe_select: assert property (@(posedge clk) disable iff (sys_rst)
    (!writeEn_n || !outEn_n) |-> !chipSel_n) else $error("Strobe without chip select.");
  a_write_width: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(writeEn_n) |-> (!writeEn_n)[*8] ##1 (!writeEn_n)[*2] ##1 writeEn_n)
    else $error("Write strobe width wrong.");
  a_read_width: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(outEn_n) |-> (!outEn_n)[*8] ##1 (!outEn_n)[*2] ##1 outEn_n)
    else $error("Read strobe width wrong.");
  // Command bytes of the two-write lock sequence.
  a_setup_byte: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_WR_SETUP && !writeEn_n) |-> dataOut == 8'h60)
    else $error("Setup write carries wrong byte.");
  a_confirm_byte: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_WR_CONFIRM && !writeEn_n) |-> dataOut == (master_r ? 8'hF1 : 8'h01))
    else $error("Confirm write carries wrong byte.");
  // Polling and the full status check.
  a_poll_ready: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(state_r == ST_CHECK) |-> ($past(dataIn[7], 11) && $past(ready_busy_out_n)))
    else $error("Check entered while engine busy.");
  a_supply_first: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_CHECK && statusSeen[3]) |=> result == 3'h1)
    else $error("Supply fault not reported first.");
  a_seq_error: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_CHECK && statusSeen[5:3] == 3'b110 && !statusSeen[1]) |=> result == 3'h3)
    else $error("Sequence error not reported.");
  a_lock_fail: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_CHECK && statusSeen[5:3] == 3'b010 && !statusSeen[1]) |=> result == 3'h4)
    else $error("Lock failure not reported.");
  a_clear_after: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_CHECK && statusSeen[1]) |=> state_r == ST_WR_CLEAR)
    else $error("Error not followed by clear.");
  a_masked_bit0: assert property (@(posedge clk) disable iff (sys_rst)
    statusSeen[0] == 1'b0) else $error("Reserved status bit not masked.");
  // Main scenarios for coverage.
  c_block_ok: cover property (@(posedge clk) doneStb && result == 3'h0 && !master_r);
  c_master: cover property (@(posedge clk) doneStb && master_r);
  c_clear: cover property (@(posedge clk) state_r == ST_WR_CLEAR);
  c_supply: cover property (@(posedge clk) doneStb && result == 3'h1);
  c_sequence: cover property (@(posedge clk) doneStb && result == 3'h3);
endmodule

// >>> testbench/flash_dev_model.sv
// Behavioural flash device answering the lock-bit set sequencer.
// Assumes host strobes change just after rising clk edges.
`timescale 1ns/1ps
module flash_dev_model
  import lock_seq_pkg::*;
(
  // Clock and fault knobs.
  input  wire logic       clk,
  input  wire logic       hvOn,
  input  wire logic       vppLow,
  input  wire logic       lockFail,
  input  wire logic       badSeq,
  input  wire logic [5:0] busyLen,
  // Flash pins.
  input  wire logic       chipSel_n,
  input  wire logic       outEn_n,
  input  wire logic       writeEn_n,
  input  wire logic [7:0] dataOut,
  input  wire logic       reset_powerdown_n,
  output logic [7:0]      dataIn,
  output logic            ready_busy_out_n,
  output logic [7:0]      lastCmd
);
  logic [7:0] err_r, wrData_r, statByte, live;
  logic [6:0] junk_r = 7'h55;  // Meaningless low bits shown while busy.
  logic [5:0] busyCnt_r;
  logic       setup_r, master_r, statMode_r, wrPend_r, busyNow;
  logic       mSet_r = 1'b0;  // Master lock survives power-down.
  assign busyNow = busyCnt_r != 6'h00;
  // ==========================================
  // Command interface and lock algorithm.
  always_ff @(posedge clk) begin
    if (!reset_powerdown_n) begin
      {err_r, busyCnt_r, setup_r, statMode_r, wrPend_r} <= '0;
    end else if (busyNow) begin
      busyCnt_r <= busyCnt_r - 6'h01;
      if (busyCnt_r == 6'h01) begin
        if (vppLow) err_r <= err_r | 8'h18;
        else if (!hvOn && (master_r || mSet_r)) err_r <= err_r | 8'h12;
        else if (lockFail) err_r <= err_r | 8'h10;
        else if (master_r) mSet_r <= 1'b1;
      end
    end else if (!chipSel_n && !writeEn_n) begin
      wrPend_r <= 1'b1;
      wrData_r <= dataOut;
    end else if (wrPend_r) begin
      wrPend_r   <= 1'b0;
      lastCmd    <= wrData_r;
      statMode_r <= wrData_r != CMD_READ_ARRAY;
      setup_r    <= wrData_r == CMD_LOCK_SETUP;
      if (setup_r && !badSeq && (wrData_r == CMD_BLOCK_CONFIRM
          || wrData_r == CMD_MASTER_CONFIRM)) begin
        busyCnt_r <= {busyLen[5:1], 1'b1};
        master_r  <= wrData_r == CMD_MASTER_CONFIRM;
      end else if (setup_r) err_r <= err_r | 8'h30;
      else if (wrData_r == CMD_CLEAR_STATUS) err_r <= 8'h00;
    end
  end
  assign ready_busy_out_n = !busyNow;
  assign statByte = busyNow ? {1'b0, junk_r}
                  : {2'b10, err_r[5:3], 1'b0, err_r[1], 1'b0};
  assign live = statMode_r ? statByte : 8'hC3;
  // released bus shows the inverse, so late sampling fails
  assign dataIn = (!chipSel_n && !outEn_n) ? live : ~live;
  always_ff @(posedge clk) begin
    junk_r <= {junk_r[5:0], ~junk_r[6]};
  end
endmodule

// >>> testbench/lock_seq_host_tb.sv
// Self-checking bench for the lock-bit set sequencer.
// Assumes the device model beside it; checks on doneStb.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module lock_seq_host_tb;
  import lock_seq_pkg::*;
  logic clk = 0, sys_rst = 1, startReq = 0, masterLock = 0, lastOp = 0, supplyOk = 1;
  logic hvOn = 0, vppLow = 0, lockFail = 0, badSeq = 0, mSet = 0;
  logic busy, doneStb, dataOe, chipSel_n, outEn_n, writeEn_n, reset_powerdown_n, ready_busy_out_n;
  logic [5:0] busyLen = 6'h01;
  logic [2:0] result;
  logic [7:0] statusSeen, dataOut, dataIn, lastCmd;
  logic [20:0] lockAddr = '0, flashAddr;
  logic [15:0] lfsr = 16'h795D;
  logic [18:0] expQ[$];  // Result, status and final command byte.
  int bad_count = 0, checks = 0;
  localparam logic [4:0] CASES [8] = '{5'h00, 5'h10, 5'h18, 5'h00, 5'h08, 5'h04, 5'h0A, 5'h09};
  always #5 clk = ~clk;
  lock_seq_host i_lock_seq_host (.clk(clk), .sys_rst(sys_rst), .startReq(startReq),
    .masterLock(masterLock), .lastOp(lastOp), .lockAddr(lockAddr), .supplyOk(supplyOk),
    .busy(busy), .doneStb(doneStb), .result(result), .statusSeen(statusSeen),
    .flashAddr(flashAddr), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
    .chipSel_n(chipSel_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n),
    .reset_powerdown_n(reset_powerdown_n), .ready_busy_out_n(ready_busy_out_n));
  flash_dev_model i_flash_dev_model (.clk(clk), .hvOn(hvOn), .vppLow(vppLow),
    .lockFail(lockFail), .badSeq(badSeq), .busyLen(busyLen), .chipSel_n(chipSel_n),
    .outEn_n(outEn_n), .writeEn_n(writeEn_n), .dataOut(dataOut),
    .reset_powerdown_n(reset_powerdown_n), .dataIn(dataIn),
    .ready_busy_out_n(ready_busy_out_n), .lastCmd(lastCmd));
  // Advances the pseudo-random source.
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    if (expQ.size() != 0) bad_count++;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Runs every outcome of the lock operation at least once.
  initial begin
    logic [2:0] r;
    logic [7:0] s;
    repeat (3) @(negedge clk);
    sys_rst = 0;
    for (int i = 0; i < 8; i++) begin
      // Midway, drop supply-ok so the reset pin must follow it.
      if (i == 4) begin
        supplyOk = 0;
        repeat (2) @(negedge clk);
        `CHK(reset_powerdown_n, 1'b0)
        supplyOk = 1;
        repeat (2) @(negedge clk);
        `CHK(reset_powerdown_n, 1'b1)
      end
      lfsr = nxt(lfsr);
      {masterLock, hvOn, vppLow, lockFail, badSeq} = CASES[i];
      lockAddr = {lfsr, lfsr[4:0]};
      lastOp = lfsr[0];
      busyLen = lfsr[10:5];
      if (vppLow) {r, s} = {RES_SUPPLY, 8'h98};
      else if (badSeq) {r, s} = {RES_SEQUENCE, 8'hB0};
      else if (!hvOn && (masterLock || mSet)) {r, s} = {RES_PROTECT, 8'h92};
      else if (lockFail) {r, s} = {RES_LOCKFAIL, 8'h90};
      else {r, s} = {RES_OK, 8'h80};
      if (r == RES_OK && masterLock) mSet = 1;
      expQ.push_back({r, s, lastOp ? CMD_READ_ARRAY : (r != RES_OK ? CMD_CLEAR_STATUS
        : (masterLock ? CMD_MASTER_CONFIRM : CMD_BLOCK_CONFIRM))});
      startReq = 1;
      @(negedge clk);
      startReq = 0;
      `CHK(busy, 1'b1)
      for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge clk);
      `CHK(busy, 1'b0)
      repeat (4) @(negedge clk);
    end
    report_and_stop();
  end
  // Takes the oldest note whenever an operation finishes.
  always @(negedge clk) begin
    logic [18:0] e;
    if (doneStb === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 19'h7FFFF;
      `CHK(result, e[18:16])
      `CHK(statusSeen, e[15:8])
      repeat (2) @(negedge clk);
      `CHK(lastCmd, e[7:0])
    end
  end
  // Every write strobe must carry the target address given with the order.
  always @(negedge clk) begin
    if (writeEn_n === 1'b0) `CHK(flashAddr, lockAddr)
  end
  // Cuts a hang short.
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
